// >>> pbm_port_mux.v
// Port B low pin-function multiplexer and port C direction register with an AXI4-Lite slave
`timescale 1ns/1ps
`include "pbm_regs.vh"
module pbm_port_mux (
    input wire SYS_CLK, // System clock, 200 MHz
    input wire RST_N, // Synchronous reset, active low (external power-on reset)
    input wire [`PBM_ADDR_W-1:0] S_AXI_AWADDR, // Write address
    input wire S_AXI_AWVALID, // Write address valid
    output reg S_AXI_AWREADY, // Write address ready
    input wire [31:0] S_AXI_WDATA, // Write data
    input wire [3:0] S_AXI_WSTRB, // Write byte strobes
    input wire S_AXI_WVALID, // Write data valid
    output reg S_AXI_WREADY, // Write data ready
    output reg [1:0] S_AXI_BRESP, // Write response
    output reg S_AXI_BVALID, // Write response valid
    input wire S_AXI_BREADY, // Write response ready
    input wire [`PBM_ADDR_W-1:0] S_AXI_ARADDR, // Read address
    input wire S_AXI_ARVALID, // Read address valid
    output reg S_AXI_ARREADY, // Read address ready
    output reg [31:0] S_AXI_RDATA, // Read data
    output reg [1:0] S_AXI_RRESP, // Read response
    output reg S_AXI_RVALID, // Read data valid
    input wire S_AXI_RREADY, // Read data ready
    input wire [7:0] PB_GPIO_OUT, // Port B general data out, pins 7..0
    input wire [7:0] PB_GPIO_OE, // Port B general output enable, pins 7..0
    input wire [7:0] PB_PIN_IN, // Port B pad input level, pins 7..0
    output reg [7:0] PB_PIN_OUT, // Port B pad output level
    output reg [7:0] PB_PIN_OE, // Port B pad output enable, high drives
    output reg [7:0] PB_GPIO_IN, // Port B pad level toward the data register
    input wire [3:0] ADDR_HI_OUT, // Address lines 19..16 from the bus controller
    input wire BUS_GRANT_OUT, // Bus grant from the arbiter
    input wire RW_DIRECTION_OUT, // Read/write direction strobe
    input wire COL_STROBE_UPPER, // Upper column address strobe
    input wire COL_STROBE_LOWER, // Lower column address strobe
    input wire ROW_STROBE_OUT, // Row address strobe
    output reg [5:0] EXT_INT_IN, // External interrupt inputs 5..0
    output reg [3:0] OUT_ENABLE_IN, // Port output enable inputs 3..0
    output reg BUS_REQUEST_IN, // Bus request input toward the arbiter
    input wire [15:0] PC_GPIO_OUT, // Port C general data out
    input wire [15:0] PC_FUNC_ACTIVE, // Port C pins currently in a non I/O function
    output reg [15:0] PC_PIN_OE // Port C general output enable, high drives
);

////////////////////////////////////////////////////////////////////////////////
// Registers
// Both control registers clear only on RST_N, which stands for the power-on reset
reg [15:0] portb_low_function_select;
reg [15:0] portc_direction;
// Operating mode: 0 normal, 1 ROM disabled, 2 single chip, 3 behaves as normal
reg [1:0] op_mode;
// Write address and data are parked here until the other half arrives
reg [`PBM_ADDR_W-1:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;

// Merge written bytes into a 16-bit register, masked to writable bits
// Only the two low strobes matter; the upper half of the bus word is ignored
function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    input [15:0] wmask;
    reg [15:0] m;
    begin
        m = old;
        if (strb[0]) begin
            m[7:0] = data[7:0];
        end
        if (strb[1]) begin
            m[15:8] = data[15:8];
        end
        merge16 = m & wmask;
    end
endfunction

// Effective 2-bit selection: single chip mode demotes the bus functions
// alt_is_bus marks pins whose third selection is an address output
function [1:0] eff_sel2;
    input [1:0] sel;
    input [1:0] mode;
    input alt_is_bus;
    begin
        eff_sel2 = sel;
        if (mode == `PBM_MODE_SINGLE) begin
            if (sel == `PBM_SEL_BUS) begin
                eff_sel2 = `PBM_SEL_IO;
            end else if (sel == `PBM_SEL_ALT && alt_is_bus) begin
                eff_sel2 = `PBM_SEL_IO;
            end
        end
    end
endfunction

// Address 17/16 pins: ROM-disabled mode forces address, single chip forces I/O
// Mode 3 is not a defined mode, so it falls back to the normal expanded mode
// The mode checks come first, so the select bit only matters in normal mode
function eff_addr;
    input sel;
    input [1:0] mode;
    begin
        if (mode == `PBM_MODE_SINGLE) begin
            eff_addr = 1'b0;
        end else if (mode == `PBM_MODE_ROMDIS) begin
            eff_addr = 1'b1;
        end else begin
            eff_addr = sel;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Write channel: address and data taken in either order, response after both
// A second write waits until the response of the first has been accepted
wire do_write = aw_held && w_held && !S_AXI_BVALID;
always @(posedge SYS_CLK) begin
    if (!RST_N) begin
        S_AXI_AWREADY <= 1'b0;
        S_AXI_WREADY <= 1'b0;
        S_AXI_BVALID <= 1'b0;
        S_AXI_BRESP <= `PBM_RESP_OKAY;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= {`PBM_ADDR_W{1'b0}};
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        portb_low_function_select <= `PBM_FSEL_RST;
        portc_direction <= `PBM_CDIR_RST;
        op_mode <= `PBM_MODE_RST;
    end else begin
        // Readies idle-toggle, so a held request is taken within two cycles
        // Dropping ready on the taking edge avoids capturing one request twice
        S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY;
        S_AXI_WREADY <= !w_held && !S_AXI_WREADY;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
        end
        if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= `PBM_RESP_OKAY;
            // Reserved bits 3 and 1 are masked so they can never be set
            if (aw_addr == `PBM_OFF_FSEL) begin
                portb_low_function_select <= merge16(portb_low_function_select, w_data, w_strb,
                    `PBM_FSEL_WMASK);
            end else if (aw_addr == `PBM_OFF_CDIR) begin
                portc_direction <= merge16(portc_direction, w_data, w_strb, 16'hffff);
            end else if (aw_addr == `PBM_OFF_MODE) begin
                // The mode register uses byte lane 0 only
                if (w_strb[0]) begin
                    op_mode <= w_data[1:0];
                end
            end else begin
                // Unmapped writes change nothing and answer an error
                S_AXI_BRESP <= `PBM_RESP_SLVERR;
            end
        end
        // The response stands until the master accepts it
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel: one read at a time, data one cycle after the address is taken
always @(posedge SYS_CLK) begin
    if (!RST_N) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b0;
        S_AXI_RDATA <= 32'h00000000;
        S_AXI_RRESP <= `PBM_RESP_OKAY;
    end else begin
        // No new address is taken while read data still waits to be taken
        S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `PBM_RESP_OKAY;
            if (S_AXI_ARADDR == `PBM_OFF_FSEL) begin
                S_AXI_RDATA <= {16'h0000, portb_low_function_select & `PBM_FSEL_WMASK};
            end else if (S_AXI_ARADDR == `PBM_OFF_CDIR) begin
                S_AXI_RDATA <= {16'h0000, portc_direction};
            end else if (S_AXI_ARADDR == `PBM_OFF_MODE) begin
                S_AXI_RDATA <= {30'h00000000, op_mode};
            end else begin
                // Unmapped addresses read zero and answer an error
                S_AXI_RDATA <= 32'h00000000;
                S_AXI_RRESP <= `PBM_RESP_SLVERR;
            end
        end
        // RDATA stands with RVALID until the master takes it
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Effective selections after the operating-mode override
// These are combinational from the register; the pad stage below adds the cycle
wire [1:0] s7 = eff_sel2(portb_low_function_select[`PBM_P7_HI -: 2], op_mode, 1'b1);
wire [1:0] s6 = eff_sel2(portb_low_function_select[`PBM_P6_HI -: 2], op_mode, 1'b1);
// Pin 5 is never demoted: its read/write strobe and enable input stay in every mode
wire [1:0] s5 = portb_low_function_select[`PBM_P5_HI -: 2];
wire [1:0] s4 = eff_sel2(portb_low_function_select[`PBM_P4_HI -: 2], op_mode, 1'b0);
wire [1:0] s3 = eff_sel2(portb_low_function_select[`PBM_P3_HI -: 2], op_mode, 1'b0);
wire [1:0] s2 = eff_sel2(portb_low_function_select[`PBM_P2_HI -: 2], op_mode, 1'b0);
wire a1 = eff_addr(portb_low_function_select[`PBM_P1_BIT], op_mode);
wire a0 = eff_addr(portb_low_function_select[`PBM_P0_BIT], op_mode);
// Pin 5 keeps its strobe in single chip mode; software must select I/O itself
wire [1:0] s5_adj = s5;

////////////////////////////////////////////////////////////////////////////////
// Pad and peripheral routing, registered so every output is a flip-flop
reg [7:0] next_out;
reg [7:0] next_oe;
reg [5:0] next_irq;
reg [3:0] next_poe;
reg next_bus_request_in;
always @* begin
    next_out = PB_GPIO_OUT;
    next_oe = PB_GPIO_OE;
    next_irq = 6'h00;
    next_poe = 4'h0;
    next_bus_request_in = 1'b0;
    // Defaults follow the general I/O data and enable; each role then overrides its pin
    // Input roles release the pad so that an outside driver sets the level
    // Each pin is one if/else-if chain, so only one role can win
    // Pin 7: interrupt 5, address 19, bus request in
    // Bus request samples the pad only while pin 7 holds that role
    // Otherwise it stays low, so the arbiter never sees a stray request
    if (s7 == `PBM_SEL_IRQ) begin
        next_oe[7] = 1'b0;
        next_irq[5] = PB_PIN_IN[7];
    end else if (s7 == `PBM_SEL_ALT) begin
        next_out[7] = ADDR_HI_OUT[3];
        next_oe[7] = 1'b1;
    end else if (s7 == `PBM_SEL_BUS) begin
        next_oe[7] = 1'b0;
        next_bus_request_in = PB_PIN_IN[7];
    end
    // Pin 6: interrupt 4, address 18, bus grant out
    // Bus grant is an output, so unlike pin 7 this role drives the pad
    if (s6 == `PBM_SEL_IRQ) begin
        next_oe[6] = 1'b0;
        next_irq[4] = PB_PIN_IN[6];
    end else if (s6 == `PBM_SEL_ALT) begin
        next_out[6] = ADDR_HI_OUT[2];
        next_oe[6] = 1'b1;
    end else if (s6 == `PBM_SEL_BUS) begin
        next_out[6] = BUS_GRANT_OUT;
        next_oe[6] = 1'b1;
    end
    // Pin 5: interrupt 3, output enable 3, read/write strobe
    if (s5_adj == `PBM_SEL_IRQ) begin
        next_oe[5] = 1'b0;
        next_irq[3] = PB_PIN_IN[5];
    end else if (s5_adj == `PBM_SEL_ALT) begin
        next_oe[5] = 1'b0;
        next_poe[3] = PB_PIN_IN[5];
    end else if (s5_adj == `PBM_SEL_BUS) begin
        next_out[5] = RW_DIRECTION_OUT;
        next_oe[5] = 1'b1;
    end
    // Pin 4: interrupt 2, output enable 2, upper column strobe
    // Strobes drive the pad; output-enable inputs leave it released
    if (s4 == `PBM_SEL_IRQ) begin
        next_oe[4] = 1'b0;
        next_irq[2] = PB_PIN_IN[4];
    end else if (s4 == `PBM_SEL_ALT) begin
        next_oe[4] = 1'b0;
        next_poe[2] = PB_PIN_IN[4];
    end else if (s4 == `PBM_SEL_BUS) begin
        next_out[4] = COL_STROBE_UPPER;
        next_oe[4] = 1'b1;
    end
    // Pin 3: interrupt 1, output enable 1, lower column strobe
    if (s3 == `PBM_SEL_IRQ) begin
        next_oe[3] = 1'b0;
        next_irq[1] = PB_PIN_IN[3];
    end else if (s3 == `PBM_SEL_ALT) begin
        next_oe[3] = 1'b0;
        next_poe[1] = PB_PIN_IN[3];
    end else if (s3 == `PBM_SEL_BUS) begin
        next_out[3] = COL_STROBE_LOWER;
        next_oe[3] = 1'b1;
    end
    // Pin 2: interrupt 0, output enable 0, row strobe
    if (s2 == `PBM_SEL_IRQ) begin
        next_oe[2] = 1'b0;
        next_irq[0] = PB_PIN_IN[2];
    end else if (s2 == `PBM_SEL_ALT) begin
        next_oe[2] = 1'b0;
        next_poe[0] = PB_PIN_IN[2];
    end else if (s2 == `PBM_SEL_BUS) begin
        next_out[2] = ROW_STROBE_OUT;
        next_oe[2] = 1'b1;
    end
    // Pins 1 and 0: address 17 and 16
    // Without an address role these pins keep the general data and enable
    if (a1) begin
        next_out[1] = ADDR_HI_OUT[1];
        next_oe[1] = 1'b1;
    end
    if (a0) begin
        next_out[0] = ADDR_HI_OUT[0];
        next_oe[0] = 1'b1;
    end
end

// One register stage on the pads trades a cycle of latency for clean outputs
// PB_GPIO_IN always follows the pad, whatever role the pin has
// Port C enable is gated by the function flags so a stale direction bit cannot drive
// Software sees the new pin roles one cycle after its write is answered
always @(posedge SYS_CLK) begin
    if (!RST_N) begin
        PB_PIN_OUT <= 8'h00;
        PB_PIN_OE <= 8'h00;
        PB_GPIO_IN <= 8'h00;
        EXT_INT_IN <= 6'h00;
        OUT_ENABLE_IN <= 4'h0;
        BUS_REQUEST_IN <= 1'b0;
        PC_PIN_OE <= 16'h0000;
    end else begin
        PB_PIN_OUT <= next_out;
        PB_PIN_OE <= next_oe;
        PB_GPIO_IN <= PB_PIN_IN;
        EXT_INT_IN <= next_irq;
        OUT_ENABLE_IN <= next_poe;
        BUS_REQUEST_IN <= next_bus_request_in;
        PC_PIN_OE <= portc_direction & ~PC_FUNC_ACTIVE;
    end
end

endmodule

// >>> pbm_regs.vh
// Register map, field positions and encodings for the port B low mux and port C direction block
`ifndef PBM_REGS_VH
`define PBM_REGS_VH
`define PBM_ADDR_W 8
`define PBM_OFF_FSEL 8'h00
`define PBM_OFF_CDIR 8'h04
`define PBM_OFF_MODE 8'h08
`define PBM_FSEL_RST 16'h0000
`define PBM_CDIR_RST 16'h0000
`define PBM_MODE_RST 2'h0
`define PBM_FSEL_WMASK 16'hfff5
`define PBM_MODE_EXT 2'h0
`define PBM_MODE_ROMDIS 2'h1
`define PBM_MODE_SINGLE 2'h2
`define PBM_SEL_IO 2'h0
`define PBM_SEL_IRQ 2'h1
`define PBM_SEL_ALT 2'h2
`define PBM_SEL_BUS 2'h3
`define PBM_P7_HI 15
`define PBM_P6_HI 13
`define PBM_P5_HI 11
`define PBM_P4_HI 9
`define PBM_P3_HI 7
`define PBM_P2_HI 5
`define PBM_P1_BIT 2
`define PBM_P0_BIT 0
`define PBM_RESP_OKAY 2'h0
`define PBM_RESP_SLVERR 2'h2
`endif

// >>> pbm_monitor.sv
// Checker on the top ports of the port B mux and port C direction block
`timescale 1ns/1ps
module pbm_monitor (
    input wire SYS_CLK, // Clock
    input wire RST_N, // Reset, low
    input wire S_AXI_BVALID, // Write resp valid
    input wire S_AXI_BREADY, // Write resp ready
    input wire [1:0] S_AXI_BRESP, // Write resp
    input wire S_AXI_RVALID, // Read valid
    input wire S_AXI_RREADY, // Read ready
    input wire [31:0] S_AXI_RDATA, // Read data
    input wire [7:0] PB_PIN_IN, // Pad level
    input wire [7:0] PB_PIN_OE, // Pad enable
    input wire [5:0] EXT_INT_IN, // Irq inputs
    input wire [3:0] OUT_ENABLE_IN, // Oe inputs
    input wire BUS_REQUEST_IN, // Bus request
    input wire [15:0] PC_FUNC_ACTIVE, // Port C pin in a function
    input wire [15:0] PC_PIN_OE // Port C enable
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////
    // An input role never drives its pad, and passes the pad level on
    irq_no_drive_a:
        assert property ((EXT_INT_IN & PB_PIN_OE[7:2]) == 6'h00) else $error("irq pin driven");
    irq_level_a:
        assert property (EXT_INT_IN[5] |-> $past(PB_PIN_IN[7])) else $error("irq level wrong");
    poe_role_a:
        assert property (OUT_ENABLE_IN[3] |-> $past(PB_PIN_IN[5]) && !PB_PIN_OE[5]) else $error("oe input wrong");
    bus_request_in_role_a:
        assert property (BUS_REQUEST_IN |-> $past(PB_PIN_IN[7]) && !PB_PIN_OE[7] && !EXT_INT_IN[5])
        else $error("bus request wrong");
    role_excl_a:
        assert property ((EXT_INT_IN[3:0] & OUT_ENABLE_IN) == 4'h0) else $error("two roles on a pin");
    dir_ignored_a:
        assert property ((PC_PIN_OE & $past(PC_FUNC_ACTIVE)) == 16'h0000) else $error("port C enable leaks");
    // The reset check must see the reset itself, so it has no disable
    reset_clears_a:
        assert property (disable iff (1'b0) !RST_N |=> PB_PIN_OE == 8'h00 && PC_PIN_OE == 16'h0000)
        else $error("reset left pins on");
    bresp_hold_a:
        assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write resp dropped");
    rdata_hold_a:
        assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    cover property (BUS_REQUEST_IN);
    cover property (OUT_ENABLE_IN[3]);
    cover property (S_AXI_BVALID && !S_AXI_BREADY);
endmodule

// >>> pbm_far.sv
// Far side model: pads with an outside driver, and on-chip signal sources
`timescale 1ns/1ps
module pbm_far (
    input wire [7:0] pin_out, // Mux pad drive
    input wire [7:0] pin_oe, // Mux pad enable
    input wire [7:0] ext_lvl, // Level an outside device drives
    input wire src, // Level of every on-chip source
    output wire [7:0] pin_in, // Resolved pad level
    output wire [3:0] addr_hi, // Address 19..16
    output wire [4:0] strobes // Grant, rw, col upper, col lower, row
);
    // A pad shows the mux drive when enabled, else the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
    // One level on all sources keeps an alternate output apart from I/O
    assign addr_hi = {4{src}};
    assign strobes = {5{src}};
endmodule

// >>> tb_top.sv
// Self-checking bench for the port B mux and port C direction block
`timescale 1ns/1ps
`include "pbm_regs.vh"
module tb_top;
    reg clk, rst_n, awv, wv, bry, arv, rry, src;
    reg [7:0] awa, ara, ext;
    reg [31:0] wd;
    reg [15:0] pc_func, f;
    reg [1:0] s;
    wire awr, wr, bv, arr, rv, bus_request_in;
    wire [1:0] bresp, rresp;
    wire [31:0] rdat;
    wire [7:0] p_out, p_oe, p_in, g_in;
    wire [5:0] irq;
    wire [3:0] poe, a_hi;
    wire [4:0] stb;
    wire [15:0] pc_oe;
    integer error_cnt, compares, i, m;
    ////////////////////////////////////////
    pbm_port_mux pbm_port_mux_i (.SYS_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
        .PB_GPIO_OUT(8'h00), .PB_GPIO_OE(8'hff), .PB_PIN_IN(p_in), .PB_PIN_OUT(p_out), .PB_PIN_OE(p_oe),
        .PB_GPIO_IN(g_in), .ADDR_HI_OUT(a_hi), .BUS_GRANT_OUT(stb[4]), .RW_DIRECTION_OUT(stb[3]),
        .COL_STROBE_UPPER(stb[2]), .COL_STROBE_LOWER(stb[1]), .ROW_STROBE_OUT(stb[0]), .EXT_INT_IN(irq),
        .OUT_ENABLE_IN(poe), .BUS_REQUEST_IN(bus_request_in), .PC_GPIO_OUT(16'h0000), .PC_FUNC_ACTIVE(pc_func),
        .PC_PIN_OE(pc_oe));
    pbm_far pbm_far_i (.pin_out(p_out), .pin_oe(p_oe), .ext_lvl(ext), .src(src), .pin_in(p_in),
        .addr_hi(a_hi), .strobes(stb));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    ////////////////////////////////////////
    // Comparison, verdict and bounded clock step shared by every test
    task check(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d compares %0d", error_cnt, compares);
            if (error_cnt == 0 && compares > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task tick(inout integer n);
        begin
            @(posedge clk);
            n = n + 1;
            if (n > 60) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t bus timeout", $time);
                finish_test;
            end
        end
    endtask
    // Bus tasks keep each channel up until its own ready edge
    task axw(input [7:0] a, input [31:0] d, input [1:0] er);
        integer n;
        reg ap, wp;
        begin
            n = 0;
            ap = 1'b1;
            wp = 1'b1;
            @(posedge clk);
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            while (ap || wp) begin
                tick(n);
                if (ap && awr) begin
                    awv <= 1'b0;
                    ap = 1'b0;
                end
                if (wp && wr) begin
                    wv <= 1'b0;
                    wp = 1'b0;
                end
            end
            while (!bv) tick(n);
            bry <= 1'b1;
            tick(n);
            check(32'(bresp), 32'(er));
            bry <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            ara <= a;
            arv <= 1'b1;
            tick(n);
            while (!arr) tick(n);
            arv <= 1'b0;
            while (!rv) tick(n);
            rry <= 1'b1;
            tick(n);
            check(rdat, exp);
            check(32'(rresp), 32'(er));
            rry <= 1'b0;
        end
    endtask
    // Expected pad roles for one select value and mode
    task pins(input [15:0] fs, input [1:0] md);
        reg [7:0] oe, out;
        reg [5:0] ei;
        reg [3:0] pe;
        reg bq;
        reg [1:0] sv;
        integer p;
        begin
            oe = 8'h03;
            out = 8'h00;
            ei = 6'h00;
            pe = 4'h0;
            bq = 1'b0;
            for (p = 2; p < 8; p = p + 1) begin
                sv = fs[2*p+1 -: 2];
                if (md == `PBM_MODE_SINGLE && (p > 5 ? sv[1] : (p < 5 && sv == 2'h3)))
                    sv = 2'h0;
                case (sv)
                    2'h0: oe[p] = 1'b1;
                    2'h1: ei[p-2] = 1'b1;
                    2'h2: if (p > 5) {oe[p], out[p]} = 2'h3; else pe[p-2] = 1'b1;
                    default: if (p == 7) bq = 1'b1; else {oe[p], out[p]} = 2'h3;
                endcase
            end
            out[1] = md == `PBM_MODE_ROMDIS || (fs[2] && md != `PBM_MODE_SINGLE);
            out[0] = md == `PBM_MODE_ROMDIS || (fs[0] && md != `PBM_MODE_SINGLE);
            repeat (2) @(posedge clk);
            check(32'(p_oe), 32'(oe));
            check(32'(p_out & p_oe), 32'(out));
            check({26'h0, irq}, {26'h0, ei});
            check({27'h0, poe, bus_request_in}, {27'h0, pe, bq});
            check({24'h0, g_in}, {24'h0, (oe & out) | ~oe});
        end
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        clk = 1'b0;
        {rst_n, awv, wv, bry, arv, rry} = 6'h00;
        {awa, ara, wd} = 48'h0;
        src = 1'b1;
        ext = 8'hff;
        pc_func = 16'h0000;
        error_cnt = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(`PBM_OFF_FSEL, 32'h0, `PBM_RESP_OKAY);
        rd(`PBM_OFF_CDIR, 32'h0, `PBM_RESP_OKAY);
        axw(`PBM_OFF_FSEL, 32'h0000fff5, `PBM_RESP_OKAY);
        rd(`PBM_OFF_FSEL, 32'h0000fff5, `PBM_RESP_OKAY);
        rd(8'h0c, 32'h0, `PBM_RESP_SLVERR);
        axw(8'h0c, 32'hffffffff, `PBM_RESP_SLVERR);
        for (m = 0; m < 4; m = m + 1) begin
            axw(`PBM_OFF_MODE, m, `PBM_RESP_OKAY);
            for (i = 0; i < 4; i = i + 1) begin
                s = i[1:0];
                f = {{6{s}}, 1'b0, s[0], 1'b0, s[0]};
                axw(`PBM_OFF_FSEL, {16'h0, f}, `PBM_RESP_OKAY);
                pins(f, m[1:0]);
            end
        end
        axw(`PBM_OFF_CDIR, 32'h0000a5c3, `PBM_RESP_OKAY);
        rd(`PBM_OFF_CDIR, 32'h0000a5c3, `PBM_RESP_OKAY);
        check(32'(pc_oe), 32'h0000a5c3);
        pc_func <= 16'h00ff;
        repeat (2) @(posedge clk);
        check(32'(pc_oe), 32'h0000a500);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`PBM_OFF_CDIR, 32'h0, `PBM_RESP_OKAY);
        rd(`PBM_OFF_FSEL, 32'h0, `PBM_RESP_OKAY);
        finish_test;
    end
endmodule
bind pbm_port_mux pbm_monitor pbm_monitor_i (.SYS_CLK, .RST_N, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .PB_PIN_IN, .PB_PIN_OE, .EXT_INT_IN, .OUT_ENABLE_IN,
    .BUS_REQUEST_IN, .PC_FUNC_ACTIVE, .PC_PIN_OE);
